/* core/srpm_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module srpm_clkdiv (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic enable,
  input wire logic [1:0] ratio_sel,
  input wire logic tdm,
  // derived clocks
  output logic frame_clk_ff,
  output logic bit_clk_ff,
  output logic frame_pulse_ff
);
  // half period of bit clock in master clocks; frame = 64 bits, or 256 in tdm
  logic [9:0] half_ff;
  logic [9:0] nxt_half;
  logic [9:0] cnt_ff;
  logic [8:0] bits_ff;
  logic [8:0] frame_bits;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // 64 bit clocks per frame: 768->12, 512->8, 256->4 mclk per bit [RQ5]
    case (ratio_sel)
      2'b01: nxt_half = 10'h006;
      2'b10: nxt_half = 10'h004;
      default: nxt_half = 10'h002;
    endcase
    // tdm master: four devices, 256 bits in a 512-clock frame whatever the ratio [RQ3]
    if (tdm) begin
      nxt_half = 10'h001;
    end
    frame_bits = tdm ? 9'(srpm_pkg::SHIFT_W * srpm_pkg::TDM_MASTER_DEVS)
                     : 9'(srpm_pkg::SHIFT_W);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_ff <= 10'h001;
      cnt_ff <= 10'h000;
      bits_ff <= 9'h000;
      bit_clk_ff <= 1'b0;
      frame_clk_ff <= 1'b0;
      frame_pulse_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
      frame_pulse_ff <= 1'b0;
      if (!enable) begin
        cnt_ff <= 10'h000;
        bits_ff <= 9'h000;
        bit_clk_ff <= 1'b0;
      end else if (cnt_ff + 10'h001 >= half_ff) begin // [RQ5]
        cnt_ff <= 10'h000;
        bit_clk_ff <= ~bit_clk_ff;
        if (bit_clk_ff) begin
          // falling bit edge advances the bit count [RQ6]
          if (bits_ff + 9'h001 >= frame_bits) begin
            bits_ff <= 9'h000;
            frame_clk_ff <= 1'b0;
            frame_pulse_ff <= 1'b1;
          end else begin
            bits_ff <= bits_ff + 9'h001;
            if (bits_ff + 9'h001 == (frame_bits >> 1)) begin
              frame_clk_ff <= 1'b1;
            end
          end
        end
      end else begin
        cnt_ff <= cnt_ff + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

/* core/srpm_pkg.sv */
// Notes on behaviour
// RQ1: load 64-bit shifter each output frame pulse
// RQ2: tdm shifts chain input through, bit clock
// RQ3: master tdm chain fixed at four devices
// RQ4: only one port may be master
// RQ5: master port divides master clock
// RQ6: master clocks for every output format
// RQ7: decode 3-bit clock mode select
// RQ8: master to 96 kHz, slave 192 kHz
// RQ9: matched-phase ratio sent out, slaves adopt
// RQ10: matched-phase slaves strapped to 100
// RQ11: matched master may run either port master
// RQ12: matched-phase needs 32 bit clocks per subframe
// RQ13: matched-phase works with every output format
// RQ14: ratio in low eight bits, rj high
// RQ15: grounded chain input device is master
// RQ16: bypass routes input samples straight out
// RQ17: no dither in bypass
// RQ18: output format select decode, rj 64 clocks
// RQ19: word width select, dither truncated bits
// RQ20: tdm frame 64 clocks per device
package srpm_pkg;
  localparam int SHIFT_W = 64;
  localparam int SUB_W = 32;
  localparam int SAMPLE_W = 24;
  localparam int RATIO_W = 8;
  localparam int TDM_MASTER_DEVS = 4;
  // axi register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RATIO = 4'h8;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_WID_LSB = 8;
  localparam int CTRL_BYP_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FMT_LJ = 2'b00,
    FMT_I2S = 2'b01,
    FMT_TDM = 2'b10,
    FMT_RJ = 2'b11
  } srpm_fmt_t;
  typedef enum logic [2:0] {
    MM_SLAVE = 3'b000,
    MM_OUT768 = 3'b001,
    MM_OUT512 = 3'b010,
    MM_OUT256 = 3'b011,
    MM_MATCHED = 3'b100,
    MM_IN768 = 3'b101,
    MM_IN512 = 3'b110,
    MM_IN256 = 3'b111
  } srpm_mode_t;
endpackage

/* core/srpm_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module srpm_shifter #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic load,
  input wire logic shift,
  input wire logic [WIDTH-1:0] load_word,
  input wire logic chain_in,
  // state
  output logic [WIDTH-1:0] word_ff
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_ff <= '0;
    end else if (load) begin
      word_ff <= load_word; // [RQ1]
    end else if (shift) begin
      // msb leaves first, chain input fills lsb so chained devices form one register
      word_ff <= {word_ff[WIDTH-2:0], chain_in}; // [RQ2]
    end
  end
endmodule
`default_nettype wire

/* core/srpm_top.sv */
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module srpm_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // samples from the converter and from the input port
  input wire logic [23:0] conv_left,
  input wire logic [23:0] conv_right,
  input wire logic [23:0] in_left,
  input wire logic [23:0] in_right,
  input wire logic [7:0] measured_ratio,
  input wire logic [23:0] dither_value,
  // output serial port, slave clocks
  input wire logic out_frame_clk_in,
  input wire logic out_bit_clk_in,
  input wire logic in_frame_clk_in,
  input wire logic in_bit_clk_in,
  input wire logic chain_in,
  input wire logic bypass_pin,
  // output serial port pins
  output logic serial_out_data,
  output logic out_frame_clk_out,
  output logic out_bit_clk_out,
  output logic out_clk_oe,
  output logic in_frame_clk_out,
  output logic in_bit_clk_out,
  output logic in_clk_oe,
  // ratio in use by the converter
  output logic [7:0] ratio_used,
  output logic matched_slave
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] ctrl_ff;
  logic [7:0] rx_ratio_ff;
  logic [7:0] ratio_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  srpm_pkg::srpm_mode_t mode;
  srpm_pkg::srpm_fmt_t fmt;
  logic [1:0] width_sel;
  logic bypass;
  assign mode = srpm_pkg::srpm_mode_t'(ctrl_ff[srpm_pkg::CTRL_MODE_LSB +: 3]);
  assign fmt = srpm_pkg::srpm_fmt_t'(ctrl_ff[srpm_pkg::CTRL_FMT_LSB +: 2]);
  assign width_sel = ctrl_ff[srpm_pkg::CTRL_WID_LSB +: 2];
  assign bypass = ctrl_ff[srpm_pkg::CTRL_BYP_BIT] | bypass_pin;

  ////////////////////////////////////////////////////////////////////////////
  // clock mode decode
  logic out_master;
  logic in_master;
  logic is_matched;
  logic [1:0] ratio_sel;
  always_comb begin
    out_master = 1'b0;
    in_master = 1'b0;
    is_matched = 1'b0;
    ratio_sel = 2'b00;
    // one encoding per mode makes two masters impossible [RQ4] [RQ7]
    case (mode)
      srpm_pkg::MM_OUT768: begin
        out_master = 1'b1;
        ratio_sel = 2'b01;
      end
      srpm_pkg::MM_OUT512: begin
        out_master = 1'b1;
        ratio_sel = 2'b10;
      end
      srpm_pkg::MM_OUT256: begin
        out_master = 1'b1;
        ratio_sel = 2'b11;
      end
      srpm_pkg::MM_MATCHED: begin
        is_matched = 1'b1;
      end
      srpm_pkg::MM_IN768: begin
        in_master = 1'b1;
        ratio_sel = 2'b01;
      end
      srpm_pkg::MM_IN512: begin
        in_master = 1'b1;
        ratio_sel = 2'b10;
      end
      srpm_pkg::MM_IN256: begin
        in_master = 1'b1;
        ratio_sel = 2'b11;
      end
      default: begin
        out_master = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock generators
  logic out_fclk;
  logic out_bclk;
  logic out_fpulse;
  logic in_fclk;
  logic in_bclk;
  srpm_clkdiv u_out_div (
    .clk(clk),
    .resetn(resetn),
    .enable(out_master),
    .ratio_sel(ratio_sel),
    .tdm(fmt == srpm_pkg::FMT_TDM),
    .frame_clk_ff(out_fclk),
    .bit_clk_ff(out_bclk),
    .frame_pulse_ff(out_fpulse)
  );
  srpm_clkdiv u_in_div (
    .clk(clk),
    .resetn(resetn),
    .enable(in_master),
    .ratio_sel(ratio_sel),
    .tdm(1'b0),
    .frame_clk_ff(in_fclk),
    .bit_clk_ff(in_bclk),
    .frame_pulse_ff()
  );

  ////////////////////////////////////////////////////////////////////////////
  // output port clocks sampled as synchronous levels
  logic fclk_d_ff;
  logic bclk_d_ff;
  logic fclk_sel;
  logic bclk_sel;
  logic frame_start;
  logic bit_rise;
  logic bit_fall;
  assign fclk_sel = out_master ? out_fclk : out_frame_clk_in;
  assign bclk_sel = out_master ? out_bclk : out_bit_clk_in;
  assign frame_start = out_master ? out_fpulse : (fclk_d_ff & ~fclk_sel);
  assign bit_rise = bclk_sel & ~bclk_d_ff;
  assign bit_fall = ~bclk_sel & bclk_d_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fclk_d_ff <= 1'b0;
      bclk_d_ff <= 1'b0;
    end else begin
      fclk_d_ff <= fclk_sel;
      bclk_d_ff <= bclk_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word assembly
  function automatic logic [31:0] pack_sub(input logic [23:0] smp, input logic [1:0] wsel,
                                           input logic dith, input logic [23:0] dv,
                                           input logic rj, input logic [7:0] ratio);
    logic [23:0] mask;
    logic [23:0] w;
    mask = 24'hFFFFFF;
    case (wsel)
      2'b01: mask = 24'hFFFFF0;
      2'b10: mask = 24'hFFFFC0;
      2'b11: mask = 24'hFFFF00;
      default: mask = 24'hFFFFFF;
    endcase
    // dither fills truncated bits before rounding off [RQ19]
    w = dith ? ((smp + (dv & ~mask)) & mask) : (smp & mask);
    // ratio in low eight bits, rj puts it high [RQ14] [RQ18]
    pack_sub = rj ? {ratio, w} : {w, ratio};
  endfunction

  logic [23:0] src_l;
  logic [23:0] src_r;
  logic dith_en;
  logic is_rj;
  logic [7:0] tx_ratio;
  logic [63:0] load_word;
  assign src_l = bypass ? in_left : conv_left; // [RQ16]
  assign src_r = bypass ? in_right : conv_right; // [RQ16]
  // bypass data is still cut to the selected width but is never dithered [RQ17]
  assign dith_en = ~bypass & (width_sel != 2'b00); // [RQ17] [RQ19]
  assign is_rj = (fmt == srpm_pkg::FMT_RJ); // [RQ18]
  // matched-phase master sends its own ratio; slave forwards nothing [RQ9] [RQ13]
  assign tx_ratio = is_matched ? 8'h00 : ratio_ff;
  assign load_word = {pack_sub(src_l, width_sel, dith_en, dither_value, is_rj, tx_ratio),
                      pack_sub(src_r, width_sel, dith_en, dither_value, is_rj, tx_ratio)};

  ////////////////////////////////////////////////////////////////////////////
  // 64-bit parallel load shift register
  logic [63:0] shreg;
  srpm_shifter #(
    .WIDTH(srpm_pkg::SHIFT_W)
  ) u_shift (
    .clk(clk),
    .resetn(resetn),
    .load(frame_start),
    .shift(bit_fall),
    .load_word(load_word),
    .chain_in(chain_in),
    .word_ff(shreg)
  ); // [RQ1] [RQ2] [RQ20]

  ////////////////////////////////////////////////////////////////////////////
  // matched-phase slave capture of the ratio from chain input
  logic [5:0] rx_bit_ff;
  logic [31:0] rx_sh_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_bit_ff <= 6'h00;
      rx_sh_ff <= 32'h0000_0000;
      rx_ratio_ff <= 8'h00;
    end else if (frame_start) begin
      rx_bit_ff <= 6'h00;
    end else if (bit_rise) begin
      rx_sh_ff <= {rx_sh_ff[30:0], chain_in};
      // fixed 32 bit clocks per subframe locate the ratio byte [RQ12]
      if (rx_bit_ff == 6'h1F) begin
        rx_ratio_ff <= is_rj ? rx_sh_ff[30:23] : {rx_sh_ff[6:0], chain_in}; // [RQ9] [RQ14]
      end
      rx_bit_ff <= rx_bit_ff + 6'h01;
    end
  end

  // strapped 100 makes this device adopt the received ratio [RQ10] [RQ15]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ratio_ff <= 8'h00;
    end else begin
      ratio_ff <= is_matched ? rx_ratio_ff : measured_ratio; // [RQ9] [RQ11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs from flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_data <= 1'b0;
      out_frame_clk_out <= 1'b0;
      out_bit_clk_out <= 1'b0;
      out_clk_oe <= 1'b0;
      in_frame_clk_out <= 1'b0;
      in_bit_clk_out <= 1'b0;
      in_clk_oe <= 1'b0;
      ratio_used <= 8'h00;
      matched_slave <= 1'b0;
    end else begin
      serial_out_data <= shreg[63]; // [RQ2]
      out_frame_clk_out <= out_fclk; // [RQ5] [RQ6]
      out_bit_clk_out <= out_bclk;
      out_clk_oe <= out_master; // [RQ4]
      in_frame_clk_out <= in_fclk;
      in_bit_clk_out <= in_bclk;
      in_clk_oe <= in_master; // [RQ4]
      ratio_used <= ratio_ff;
      matched_slave <= is_matched;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one answer cycle after both halves arrive
  logic do_wr;
  assign do_wr = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srpm_pkg::RESP_OKAY;
      ctrl_ff <= srpm_pkg::CTRL_RESET;
    end else begin
      s_axi_awready <= ~aw_hold_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({awaddr_ff[3:2], 2'b00} == srpm_pkg::OFS_CTRL) begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_ff[i]) begin
              ctrl_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
            end
          end
          s_axi_bresp <= srpm_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= srpm_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= srpm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= srpm_pkg::RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
          srpm_pkg::OFS_CTRL: s_axi_rdata <= ctrl_ff;
          srpm_pkg::OFS_STATUS: s_axi_rdata <= {26'h0, bypass, is_matched, in_master,
                                                out_master, 2'b00};
          srpm_pkg::OFS_RATIO: s_axi_rdata <= {24'h0, ratio_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= srpm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_one_master: assert property (@(posedge clk) disable iff (!resetn)
    !(out_clk_oe && in_clk_oe)) else $error("both ports master"); // [RQ4]
  a_load_frame: assert property (@(posedge clk) disable iff (!resetn)
    frame_start |=> shreg == $past(load_word)) else $error("no parallel load"); // [RQ1]
  a_shift_chain: assert property (@(posedge clk) disable iff (!resetn)
    (bit_fall && !frame_start) |=> shreg[0] == $past(chain_in)) else $error("bad shift"); // [RQ2]
  a_serial_msb: assert property (@(posedge clk) disable iff (!resetn)
    ##1 serial_out_data == $past(shreg[63])) else $error("serial out wrong"); // [RQ2]
  a_bypass_nodith: assert property (@(posedge clk) disable iff (!resetn)
    bypass |-> !dith_en) else $error("dither in bypass"); // [RQ17]
  a_bypass_path: assert property (@(posedge clk) disable iff (!resetn)
    (bypass && width_sel == 2'b00 && !is_rj) |-> load_word[63:40] == in_left)
    else $error("bypass data altered"); // [RQ16]
  a_matched_ratio: assert property (@(posedge clk) disable iff (!resetn)
    (is_matched && $stable(rx_ratio_ff)) |=> ratio_ff == $past(rx_ratio_ff))
    else $error("slave ignores ratio"); // [RQ9]
  a_mode_oe: assert property (@(posedge clk) disable iff (!resetn)
    (mode == srpm_pkg::MM_OUT512) |=> out_clk_oe) else $error("out master not driven"); // [RQ7]
  a_ratio_low: assert property (@(posedge clk) disable iff (!resetn)
    !is_rj |-> load_word[7:0] == tx_ratio) else $error("ratio not in low byte"); // [RQ14]
endmodule
`default_nettype wire

/* tb/asrc_serial_port_modes_test.sv */
`timescale 1ns/1ps
`default_nettype none
module asrc_serial_port_modes_test;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [23:0] conv_left, conv_right, in_left, in_right, dither_value;
  logic [7:0] measured_ratio, ratio_used, nbits, nfr;
  logic out_frame_clk_in, out_bit_clk_in, in_frame_clk_in, in_bit_clk_in, chain_in, bypass_pin;
  logic serial_out_data, out_frame_clk_out, out_bit_clk_out, out_clk_oe, run;
  logic in_frame_clk_out, in_bit_clk_out, in_clk_oe, matched_slave;
  logic [127:0] chain_word, got;
  logic [3:0] mon;
  int fails, check_count;
  assign mon = {in_frame_clk_out, out_frame_clk_out, in_bit_clk_out, out_bit_clk_out};
  srpm_top u_dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conv_left, .conv_right, .in_left, .in_right, .measured_ratio,
    .dither_value, .out_frame_clk_in, .out_bit_clk_in, .in_frame_clk_in, .in_bit_clk_in,
    .chain_in, .bypass_pin, .serial_out_data, .out_frame_clk_out, .out_bit_clk_out,
    .out_clk_oe, .in_frame_clk_out, .in_bit_clk_out, .in_clk_oe, .ratio_used, .matched_slave);
  srpm_dsp_model u_dsp (.clk, .run, .nbits, .chain_word, .serial_out_data, .out_bit_clk_in,
    .out_frame_clk_in, .chain_in, .got, .nfr);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [127:0] e, input logic [127:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic guard(input bit bad);
    if (bad) begin
      fails++;
      $display("mismatch wait expected answer seen timeout");
      results();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit ta;
    bit tw;
    n = 0;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready && !ta) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !tw) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ta && tw) && n < 1000);
    while (s_axi_bvalid !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    guard(n >= 1000);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 1000);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    guard(n >= 1000);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic lvl(input int s, input logic v, inout int n);
    int k;
    for (k = 0; k < 1000 && mon[s] !== v; k++) begin
      @(posedge clk);
      n++;
    end
    guard(k >= 1000);
  endtask
  // rise to rise, in clk cycles
  task automatic per(input int s, output int n);
    n = 0;
    lvl(s, 1'b0, n);
    lvl(s, 1'b1, n);
    n = 0;
    lvl(s, 1'b0, n);
    lvl(s, 1'b1, n);
  endtask
  task automatic rnd();
    conv_left <= 24'($urandom);
    conv_right <= 24'($urandom);
    in_left <= 24'($urandom);
    in_right <= 24'($urandom);
    measured_ratio <= 8'($urandom);
    // low bits never zero, so any dither leaking into output would show
    dither_value <= 24'($urandom) | 24'h0000FF;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] f,
                                     input logic [1:0] w);
    return {19'h0, 1'b0, 2'h0, w, 2'h0, f, 1'b0, m};
  endfunction
  function automatic logic [63:0] xw(input logic rj, input logic [23:0] l,
                                     input logic [23:0] r, input logic [7:0] q,
                                     input logic [1:0] w);
    logic [23:0] k;
    k = 24'hFFFFFF << (w == 2'h0 ? 0 : w == 2'h1 ? 4 : w == 2'h2 ? 6 : 8);
    return rj ? {q, l & k, q, r & k} : {l & k, q, r & k, q};
  endfunction
  task automatic dat(input string s, input logic [31:0] c, input logic [7:0] nb,
                     input logic [127:0] cwd, input logic [127:0] e);
    int n;
    logic [7:0] f0;
    logic [1:0] r;
    wr(srpm_pkg::OFS_CTRL, c, r);
    nbits <= nb;
    chain_word <= cwd;
    run <= 1'b1;
    f0 = nfr;
    for (n = 0; n < 5000 && nfr - f0 < 8'h02; n++) @(posedge clk);
    guard(n >= 5000);
    run <= 1'b0;
    chk(s, e, nb == 8'h80 ? got : {got[127:64], 64'h0});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] f;
    logic [7:0] q;
    logic [63:0] c64;
    logic [127:0] e;
    int m;
    int n;
    int h;
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_left, conv_right, in_left, in_right} = '0;
    {dither_value, measured_ratio, nbits, chain_word, run, bypass_pin} = '0;
    {in_frame_clk_in, in_bit_clk_in, fails, check_count} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(82));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(srpm_pkg::OFS_CTRL, d, r);
    chk("ctrl reset", srpm_pkg::CTRL_RESET, d);
    wr(srpm_pkg::OFS_STATUS, 32'hFFFFFFFF, r);
    chk("read only write", srpm_pkg::RESP_SLVERR, r);
    wr(4'hC, 32'h00000001, r);
    chk("unmapped write", srpm_pkg::RESP_SLVERR, r);
    rd(4'hC, d, r);
    chk("unmapped read", {srpm_pkg::RESP_SLVERR, 32'h0}, {r, d});
    d = cw(3'($urandom), 2'($urandom), 2'($urandom));
    wr(srpm_pkg::OFS_CTRL, d, r);
    rd(srpm_pkg::OFS_CTRL, e[31:0], r);
    chk("ctrl readback", d, e[31:0]);
    $display("test registers done");
    for (m = 0; m < 8; m++) begin
      wr(srpm_pkg::OFS_CTRL, cw(3'(m), 2'h0, 2'h0), r);
      repeat (4) @(posedge clk);
      chk("out oe", m > 0 && m < 4, out_clk_oe);
      chk("in oe", m > 4, in_clk_oe);
      chk("matched", m == 4, matched_slave);
      rd(srpm_pkg::OFS_STATUS, d, r);
      chk("status", {m == 4, m > 4, m > 0 && m < 4, 2'h0}, d[4:0]);
      h = 4 - (m % 4);
      if (m % 4 != 0) begin
        per(m / 4, n);
        chk("bit period", 4 * h, n);
        per(2 + m / 4, n);
        chk("frame period", 256 * h, n);
      end
    end
    wr(srpm_pkg::OFS_CTRL, cw(3'h3, 2'h2, 2'h0), r);
    per(0, n);
    chk("tdm bit period", 2, n);
    per(2, n);
    chk("tdm frame period", 512, n);
    $display("test clock modes done");
    rnd();
    e = {xw(1'b0, conv_left, conv_right, measured_ratio, 2'h0), 64'h0};
    dat("i2s word", cw(3'h0, 2'h1, 2'h0), 8'h40, '0, e);
    rnd();
    e = {xw(1'b1, conv_left, conv_right, measured_ratio, 2'h0), 64'h0};
    dat("rj word", cw(3'h0, 2'h3, 2'h0), 8'h40, '0, e);
    rnd();
    c64 = {$urandom, $urandom};
    e = {xw(1'b0, conv_left, conv_right, measured_ratio, 2'h0), c64};
    dat("tdm chain", cw(3'h0, 2'h2, 2'h0), 8'h80, {c64, 64'h0}, e);
    $display("test output words done");
    bypass_pin <= 1'b1;
    for (m = 0; m < 4; m++) begin
      rnd();
      e = {xw(1'b0, in_left, in_right, measured_ratio, 2'(m)), 64'h0};
      dat("bypass word", cw(3'h0, 2'h0, 2'(m)), 8'h40, '0, e);
    end
    rd(srpm_pkg::OFS_STATUS, d, r);
    chk("bypass status", 1'b1, d[5]);
    bypass_pin <= 1'b0;
    rnd();
    e = {xw(1'b0, conv_left + (dither_value & 24'hFF), conv_right + (dither_value & 24'hFF),
            measured_ratio, 2'h3), 64'h0};
    dat("dither word", cw(3'h0, 2'h0, 2'h3), 8'h40, '0, e);
    $display("test bypass done");
    for (m = 0; m < 3; m++) begin
      f = (m == 0) ? 2'h0 : (m == 1) ? 2'h3 : 2'h2;
      q = (m == 2) ? 8'hFF : 8'($urandom);
      rnd();
      c64 = (f == 2'h3) ? {q, 24'h0, q, 24'h0} : {24'h0, q, 24'h0, q};
      e = {xw(f == 2'h3, conv_left, conv_right, 8'h00, 2'h0), 64'h0};
      dat("matched word", cw(3'h4, f, 2'h0), 8'h40, {c64, 64'h0}, e);
      chk("ratio used", q, ratio_used);
      rd(srpm_pkg::OFS_RATIO, d, r);
      chk("ratio reg", q, d[7:0]);
    end
    $display("test matched phase done");
    results();
  end
endmodule
`default_nettype wire

/* tb/srpm_dsp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module srpm_dsp_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic run,
  input wire logic [7:0] nbits,
  input wire logic [127:0] chain_word,
  // serial port pins
  input wire logic serial_out_data,
  output logic out_bit_clk_in,
  output logic out_frame_clk_in,
  output logic chain_in,
  // capture
  output logic [127:0] got,
  output logic [7:0] nfr
);
  int k;
  initial begin
    out_bit_clk_in = 1'b1;
    out_frame_clk_in = 1'b1;
    chain_in = 1'b0;
    got = '0;
    nfr = '0;
    forever begin
      @(posedge clk);
      // clocks stand still between frames; slow bit clock keeps the slave rate low
      if (run) begin
        for (k = 0; k < int'(nbits); k++) begin
          out_bit_clk_in <= 1'b0;
          if (k == 0) begin
            out_frame_clk_in <= 1'b0;
          end
          if (k == int'(nbits) / 2) begin
            out_frame_clk_in <= 1'b1;
          end
          repeat (2) @(posedge clk);
          // chain bit moves after the shift the fall started, before the rise samples it
          chain_in <= chain_word[127-k];
          repeat (2) @(posedge clk);
          out_bit_clk_in <= 1'b1;
          repeat (4) @(posedge clk);
          got[127-k] <= serial_out_data;
        end
        nfr <= nfr + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
